// >>> hdl/err_regs_pkg.sv
// register map, field positions and reset values of the pcie ecc / lan parity error bank
// assumes a 32-bit axi4-lite register bus with byte addressing
package err_regs_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [15:0] ACL01_OFF = 16'h5b7c;
  localparam logic [15:0] ACL23_OFF = 16'h5b80;
  localparam logic [15:0] GPAR_CTL_OFF = 16'h5ba0;
  localparam logic [15:0] ECC_CTL_OFF = 16'h5ba4;
  localparam logic [15:0] ECC_STS_OFF = 16'h5bac;
  localparam logic [15:0] LAN_CTL_OFF = 16'h5f54;
  localparam logic [15:0] LAN_STS_OFF = 16'h5f58;
  localparam logic [15:0] FATAL_IND_OFF = 16'h5f5c;
  localparam logic [15:0] FATAL_MASK_OFF = 16'h1088;
  localparam logic [15:0] IRQ_STS_OFF = 16'h5f60;
  localparam logic [15:0] IRQ_MASK_OFF = 16'h5f64;

  // ****************************************
  // field positions
  // ****************************************
  localparam int GLOBAL_PARITY_ENABLE_BIT = 0;
  localparam int ECC_TXWR_EN_BIT = 12;
  localparam int ECC_RETRY_EN_BIT = 14;
  localparam int ECC_TXWR_ERR_BIT = 4;
  localparam int ECC_RETRY_ERR_BIT = 5;
  localparam int RETX_EN_BIT = 9;
  localparam int RETX_ERR_BIT = 9;
  localparam int FATAL_IND_BIT = 0;
  localparam int FATAL_MASK_BIT = 0;
  localparam int ACL_LO_LSB = 0;
  localparam int ACL_HI_LSB = 16;
  localparam int ACL_W = 16;

  // interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_TXWR_BIT = 0;
  localparam int IRQ_RETRY_BIT = 1;
  localparam int IRQ_RETX_BIT = 2;

  // ****************************************
  // reset and fixed values
  // ****************************************
  localparam logic [11:0] ECC_CTL_LOW_FIXED = 12'h511;
  localparam logic ECC_EN_RST = 1'b1;
  localparam logic RETX_EN_RST = 1'b1;
  localparam logic GLOBAL_PARITY_ENABLE_RST = 1'b0;
  localparam logic FATAL_MASK_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [15:0] ACL_RST = 16'h0000;

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : err_regs_pkg

// >>> hdl/sticky_event_flags.sv
// bank of sticky event flags, one per bit
// assumes set and clear are single-cycle strobes in the clk domain
`timescale 1ns/1ps
module sticky_event_flags #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // strobes
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // state
  output logic [W-1:0] flags
);

  // ****************************************
  // per-bit flag
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      // set beats clear so an event in the clearing cycle survives
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          flags[i] <= 1'b0;
        else if (ce)
          flags[i] <= set[i] | (flags[i] & ~clr[i]);
      end
    end
  endgenerate

endmodule : sticky_event_flags

// >>> hdl/pcie_ecc_lan_parity_err_regs.sv
// pcie ecc / lan re-transmit parity error control and status bank with axi4-lite slave
// assumes error detectors outside deliver one-cycle strobes in the clk domain
//
// Functional notes
// - tx write-data ram ecc check runs only while ecc control bit 12 set; resets 1
// - retry buffer ram ecc check runs only while ecc control bit 14 set; resets 1
// - tx write-data correctable ecc error sets status bit 4; write one clears
// - retry buffer correctable ecc error sets status bit 5; write one clears
// - four read-only 16-bit access-list words, two per register, low then high
// - access-list words return to zero only on pcie reset
// - re-transmit buffer parity detection only while lan control bit 9 set; resets 1
// - detected re-transmit parity error sets lan status bit 9; write one clears
// - all packet transmission halts while the re-transmit parity status is set
// - re-transmit parity error raises fatal indication and, unless masked, fatal cause
// - fatal cause needs fatal indication mask bit 0 set; mask resets to one
// - global parity enable low disables all parity checks; reset only by lan power-good
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module pcie_ecc_lan_parity_err_regs #(
  parameter int ADDR_W = 16
) (
  // clock, resets and enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pcie_rst_n,
  input wire logic lan_power_good,
  input wire logic ce,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // access-list word load from the device side
  input wire logic acl_load,
  input wire logic [15:0] access_list_word_0,
  input wire logic [15:0] access_list_word_1,
  input wire logic [15:0] access_list_word_2,
  input wire logic [15:0] access_list_word_3,
  // error strobes from the checkers
  input wire logic txwr_ecc_corr_err,
  input wire logic retry_ecc_corr_err,
  input wire logic retx_parity_err,
  // check enables toward the checkers
  output logic txwr_ecc_check_en,
  output logic retry_ecc_check_en,
  output logic retx_parity_check_en,
  // fatal handling
  output logic tx_halt,
  output logic lan_fatal_parity_indication,
  output logic fatal_error_interrupt_cause,
  // interrupt
  output logic irq
);

  // ****************************************
  // bus state machines
  // ****************************************
  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP = 2'h2
  } wr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rd_state_e;

  wr_state_e wr_state;
  wr_state_e next_wr_state;
  rd_state_e rd_state;
  rd_state_e next_rd_state;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ****************************************
  // register state
  // ****************************************
  logic ecc_txwr_en;
  logic ecc_retry_en;
  logic retx_en;
  logic global_parity_enable;
  logic fatal_mask;
  logic [err_regs_pkg::IRQ_W-1:0] irq_mask;
  logic [15:0] acl_word [4];
  logic [2:0] err_flags;
  logic [err_regs_pkg::IRQ_W-1:0] irq_flags;

  // ****************************************
  // handshakes and write decode
  // ****************************************
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  wire do_write = (wr_state == WR_COLLECT) & aw_held & w_held;
  wire [15:0] wa = 16'(awaddr_q);
  wire [15:0] ra = 16'(araddr);

  wire wr_gpar = do_write & (wa == err_regs_pkg::GPAR_CTL_OFF);
  wire wr_ecc_ctl = do_write & (wa == err_regs_pkg::ECC_CTL_OFF);
  wire wr_ecc_sts = do_write & (wa == err_regs_pkg::ECC_STS_OFF);
  wire wr_lan_ctl = do_write & (wa == err_regs_pkg::LAN_CTL_OFF);
  wire wr_lan_sts = do_write & (wa == err_regs_pkg::LAN_STS_OFF);
  wire wr_fmask = do_write & (wa == err_regs_pkg::FATAL_MASK_OFF);
  wire wr_imask = do_write & (wa == err_regs_pkg::IRQ_MASK_OFF);

  // read-only registers accept writes silently; only unknown offsets are refused
  wire wa_mapped = (wa == err_regs_pkg::ACL01_OFF) | (wa == err_regs_pkg::ACL23_OFF) |
                   (wa == err_regs_pkg::GPAR_CTL_OFF) | (wa == err_regs_pkg::ECC_CTL_OFF) |
                   (wa == err_regs_pkg::ECC_STS_OFF) | (wa == err_regs_pkg::LAN_CTL_OFF) |
                   (wa == err_regs_pkg::LAN_STS_OFF) | (wa == err_regs_pkg::FATAL_IND_OFF) |
                   (wa == err_regs_pkg::FATAL_MASK_OFF) | (wa == err_regs_pkg::IRQ_STS_OFF) |
                   (wa == err_regs_pkg::IRQ_MASK_OFF);

  // byte-lane qualified write bits
  wire lane_en0 = wstrb_q[err_regs_pkg::GLOBAL_PARITY_ENABLE_BIT / 8];
  wire lane_txwr_en = wstrb_q[err_regs_pkg::ECC_TXWR_EN_BIT / 8];
  wire lane_retry_en = wstrb_q[err_regs_pkg::ECC_RETRY_EN_BIT / 8];
  wire lane_retx_en = wstrb_q[err_regs_pkg::RETX_EN_BIT / 8];
  wire lane_ecc_sts = wstrb_q[err_regs_pkg::ECC_TXWR_ERR_BIT / 8];
  wire lane_lan_sts = wstrb_q[err_regs_pkg::RETX_ERR_BIT / 8];

  // ****************************************
  // write channel
  // ****************************************
  always_comb
  begin
    next_wr_state = wr_state;
    case (wr_state)
      WR_COLLECT:
        if (do_write)
          next_wr_state = WR_RESP;
      WR_RESP:
        if (bready)
          next_wr_state = WR_COLLECT;
      default:
        next_wr_state = WR_COLLECT;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_state <= WR_COLLECT;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= err_regs_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      wr_state <= next_wr_state;
      if (aw_take)
      begin
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= wa_mapped ? err_regs_pkg::RESP_OKAY : err_regs_pkg::RESP_SLVERR;
      end
      else if (bvalid & bready)
      begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // payload registers carry no reset; they are only read once held
  always_ff @(posedge clk)
  begin
    if (ce & aw_take)
      awaddr_q <= awaddr;
    if (ce & w_take)
    begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ecc_txwr_en <= err_regs_pkg::ECC_EN_RST;
      ecc_retry_en <= err_regs_pkg::ECC_EN_RST;
      retx_en <= err_regs_pkg::RETX_EN_RST;
      fatal_mask <= err_regs_pkg::FATAL_MASK_RST;
      irq_mask <= err_regs_pkg::IRQ_MASK_RST;
    end
    else if (ce)
    begin
      if (wr_ecc_ctl & lane_txwr_en)
        ecc_txwr_en <= wdata_q[err_regs_pkg::ECC_TXWR_EN_BIT];
      if (wr_ecc_ctl & lane_retry_en)
        ecc_retry_en <= wdata_q[err_regs_pkg::ECC_RETRY_EN_BIT];
      if (wr_lan_ctl & lane_retx_en)
        retx_en <= wdata_q[err_regs_pkg::RETX_EN_BIT];
      if (wr_fmask & lane_en0)
        fatal_mask <= wdata_q[err_regs_pkg::FATAL_MASK_BIT];
      if (wr_imask & lane_en0)
        irq_mask <= wdata_q[err_regs_pkg::IRQ_W-1:0];
    end
  end

  // global parity enable lives on the power-good reset so a device reset keeps it
  always_ff @(posedge clk or negedge lan_power_good)
  begin
    if (!lan_power_good)
      global_parity_enable <= err_regs_pkg::GLOBAL_PARITY_ENABLE_RST;
    else if (ce & wr_gpar & lane_en0)
      global_parity_enable <= wdata_q[err_regs_pkg::GLOBAL_PARITY_ENABLE_BIT];
  end

  // ****************************************
  // access-list words
  // ****************************************
  wire [15:0] acl_in [4];
  assign acl_in[0] = access_list_word_0;
  assign acl_in[1] = access_list_word_1;
  assign acl_in[2] = access_list_word_2;
  assign acl_in[3] = access_list_word_3;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_acl
      always_ff @(posedge clk or negedge pcie_rst_n)
      begin
        if (!pcie_rst_n)
          acl_word[g] <= err_regs_pkg::ACL_RST;
        else if (ce & acl_load)
          acl_word[g] <= acl_in[g];
      end
    end
  endgenerate

  // ****************************************
  // error events and status flags
  // ****************************************
  // correctable errors log and can raise irq; no stall or halt is derived from them
  wire ev_txwr = txwr_ecc_corr_err & ecc_txwr_en;
  wire ev_retry = retry_ecc_corr_err & ecc_retry_en;
  wire ev_retx = retx_parity_err & retx_en & global_parity_enable;

  wire [2:0] err_set = {ev_retx, ev_retry, ev_txwr};
  wire clr_txwr = wr_ecc_sts & lane_ecc_sts & wdata_q[err_regs_pkg::ECC_TXWR_ERR_BIT];
  wire clr_retry = wr_ecc_sts & lane_ecc_sts & wdata_q[err_regs_pkg::ECC_RETRY_ERR_BIT];
  wire clr_retx = wr_lan_sts & lane_lan_sts & wdata_q[err_regs_pkg::RETX_ERR_BIT];
  wire [2:0] err_clr = {clr_retx, clr_retry, clr_txwr};

  sticky_event_flags #(
    .W(3)
  ) u_err_flags (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .set(err_set),
    .clr(err_clr),
    .flags(err_flags)
  );

  wire txwr_flag = err_flags[0];
  wire retry_flag = err_flags[1];
  wire retx_flag = err_flags[2];

  // interrupt status is cleared by reading it
  wire rd_irq_sts = ar_take & (ra == err_regs_pkg::IRQ_STS_OFF);
  wire [err_regs_pkg::IRQ_W-1:0] irq_set = err_set;
  wire [err_regs_pkg::IRQ_W-1:0] irq_clr = {err_regs_pkg::IRQ_W{rd_irq_sts}};

  sticky_event_flags #(
    .W(err_regs_pkg::IRQ_W)
  ) u_irq_flags (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .set(irq_set),
    .clr(irq_clr),
    .flags(irq_flags)
  );

  // ****************************************
  // outputs toward the datapath
  // ****************************************
  // one cycle behind the enable registers and flags; keeps every output on a flop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txwr_ecc_check_en <= 1'b0;
      retry_ecc_check_en <= 1'b0;
      retx_parity_check_en <= 1'b0;
      tx_halt <= 1'b0;
      lan_fatal_parity_indication <= 1'b0;
      fatal_error_interrupt_cause <= 1'b0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      txwr_ecc_check_en <= ecc_txwr_en;
      retry_ecc_check_en <= ecc_retry_en;
      retx_parity_check_en <= retx_en & global_parity_enable;
      tx_halt <= retx_flag;
      lan_fatal_parity_indication <= retx_flag;
      fatal_error_interrupt_cause <= retx_flag & fatal_mask;
      irq <= |(irq_flags & irq_mask);
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  wire [31:0] rd_acl01 = {acl_word[1], acl_word[0]};
  wire [31:0] rd_acl23 = {acl_word[3], acl_word[2]};
  wire [31:0] rd_gpar = 32'(global_parity_enable) << err_regs_pkg::GLOBAL_PARITY_ENABLE_BIT;
  wire [31:0] rd_ecc_ctl = (32'(ecc_txwr_en) << err_regs_pkg::ECC_TXWR_EN_BIT) |
                           (32'(ecc_retry_en) << err_regs_pkg::ECC_RETRY_EN_BIT) |
                           32'(err_regs_pkg::ECC_CTL_LOW_FIXED);
  wire [31:0] rd_ecc_sts = (32'(txwr_flag) << err_regs_pkg::ECC_TXWR_ERR_BIT) |
                           (32'(retry_flag) << err_regs_pkg::ECC_RETRY_ERR_BIT);
  wire [31:0] rd_lan_ctl = 32'(retx_en) << err_regs_pkg::RETX_EN_BIT;
  wire [31:0] rd_lan_sts = 32'(retx_flag) << err_regs_pkg::RETX_ERR_BIT;
  wire [31:0] rd_find = 32'(retx_flag) << err_regs_pkg::FATAL_IND_BIT;
  wire [31:0] rd_fmask = 32'(fatal_mask) << err_regs_pkg::FATAL_MASK_BIT;
  wire [31:0] rd_ists = 32'(irq_flags);
  wire [31:0] rd_imask = 32'(irq_mask);

  logic [31:0] rd_value;
  logic rd_hit;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ra == err_regs_pkg::ACL01_OFF)
      rd_value = rd_acl01;
    else if (ra == err_regs_pkg::ACL23_OFF)
      rd_value = rd_acl23;
    else if (ra == err_regs_pkg::GPAR_CTL_OFF)
      rd_value = rd_gpar;
    else if (ra == err_regs_pkg::ECC_CTL_OFF)
      rd_value = rd_ecc_ctl;
    else if (ra == err_regs_pkg::ECC_STS_OFF)
      rd_value = rd_ecc_sts;
    else if (ra == err_regs_pkg::LAN_CTL_OFF)
      rd_value = rd_lan_ctl;
    else if (ra == err_regs_pkg::LAN_STS_OFF)
      rd_value = rd_lan_sts;
    else if (ra == err_regs_pkg::FATAL_IND_OFF)
      rd_value = rd_find;
    else if (ra == err_regs_pkg::FATAL_MASK_OFF)
      rd_value = rd_fmask;
    else if (ra == err_regs_pkg::IRQ_STS_OFF)
      rd_value = rd_ists;
    else if (ra == err_regs_pkg::IRQ_MASK_OFF)
      rd_value = rd_imask;
    else
      rd_hit = 1'b0;
  end

  always_comb
  begin
    next_rd_state = rd_state;
    case (rd_state)
      RD_IDLE:
        if (ar_take)
          next_rd_state = RD_DATA;
      RD_DATA:
        if (rready)
          next_rd_state = RD_IDLE;
      default:
        next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_state <= RD_IDLE;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= err_regs_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      rd_state <= next_rd_state;
      if (ar_take)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_value;
        rresp <= rd_hit ? err_regs_pkg::RESP_OKAY : err_regs_pkg::RESP_SLVERR;
      end
      else if (rvalid & rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : pcie_ecc_lan_parity_err_regs

// >>> verification/err_regs_props.sv
// concurrent checks on the ports of the error-detection register bank
// assumes one clock domain and the bench holding ce high
`timescale 1ns/1ps
module err_regs_checker #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // events and outputs
  input wire logic txwr_ecc_corr_err,
  input wire logic retry_ecc_corr_err,
  input wire logic retx_parity_err,
  input wire logic txwr_ecc_check_en,
  input wire logic retry_ecc_check_en,
  input wire logic retx_parity_check_en,
  input wire logic tx_halt,
  input wire logic lan_fatal_parity_indication,
  input wire logic fatal_error_interrupt_cause,
  input wire logic irq
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // a strobe whose enable was already off when it arrived
  sequence s_gated_retx;
    retx_parity_err ##1 (!retx_parity_check_en && !tx_halt);
  endsequence

  property p_retx_gated;
    s_gated_retx |=> !tx_halt;
  endproperty
  property p_halt_source;
    $rose(tx_halt) |-> $past(retx_parity_err, 2);
  endproperty
  property p_halt_fatal;
    tx_halt == lan_fatal_parity_indication;
  endproperty
  property p_cause_ind;
    fatal_error_interrupt_cause |-> lan_fatal_parity_indication;
  endproperty
  // enables move only after a completed write or a reset release
  property p_txwr_en;
    $changed(txwr_ecc_check_en) |-> $past(bvalid) || !$past(arst_n, 2);
  endproperty
  property p_retry_en;
    $changed(retry_ecc_check_en) |-> $past(bvalid) || !$past(arst_n, 2);
  endproperty
  property p_bresp_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rdata_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_unmapped_rd;
    arvalid && arready && araddr == '0 |=> rvalid && rresp == err_regs_pkg::RESP_SLVERR && rdata == 32'h0;
  endproperty
  property p_irq_cause;
    $rose(irq) |-> $past(txwr_ecc_corr_err | retry_ecc_corr_err | retx_parity_err, 2) || $past(bvalid);
  endproperty

  a_retx_gated: assert property (p_retx_gated) else $error("retx strobe acted while disabled");
  a_halt_source: assert property (p_halt_source) else $error("halt rose without parity strobe");
  a_halt_fatal: assert property (p_halt_fatal) else $error("halt and fatal indication differ");
  a_cause_ind: assert property (p_cause_ind) else $error("fatal cause without indication");
  a_txwr_en: assert property (p_txwr_en) else $error("write-data ecc enable moved alone");
  a_retry_en: assert property (p_retry_en) else $error("retry ecc enable moved alone");
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped early");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped early");
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not refused");
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
endmodule : err_regs_checker

bind pcie_ecc_lan_parity_err_regs err_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> verification/tb.sv
// self-checking bench for the error-detection register bank
// assumes one 125 MHz clock; the bench drives every port itself
`timescale 1ns/1ps
module tb;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [1:0] SE = err_regs_pkg::RESP_SLVERR;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic pcie_rst_n = 1'b0;
  logic lan_power_good = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] prot = 3'h0;
  logic acl_load = 1'b0;
  logic [15:0] acl_w [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [2:0] ev_v = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic txwr_en, retry_en, retx_en, tx_halt, fatal_ind, fatal_cause, irq;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  pcie_ecc_lan_parity_err_regs #(.ADDR_W(16)) uut (
    .clk(clk), .arst_n(arst_n), .pcie_rst_n(pcie_rst_n), .lan_power_good(lan_power_good), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .acl_load(acl_load), .access_list_word_0(acl_w[0]), .access_list_word_1(acl_w[1]),
    .access_list_word_2(acl_w[2]), .access_list_word_3(acl_w[3]),
    .txwr_ecc_corr_err(ev_v[0]), .retry_ecc_corr_err(ev_v[1]), .retx_parity_err(ev_v[2]),
    .txwr_ecc_check_en(txwr_en), .retry_ecc_check_en(retry_en), .retx_parity_check_en(retx_en),
    .tx_halt(tx_halt), .lan_fatal_parity_indication(fatal_ind),
    .fatal_error_interrupt_cause(fatal_cause), .irq(irq));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk32

  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  // bready is held low two edges so the response must stand
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = err_regs_pkg::RESP_OKAY);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    while (!(ad && dd))
    begin
      @(posedge clk);
      ad = ad | (awvalid & awready);
      dd = dd | (wvalid & wready);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    chk32("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er = err_regs_pkg::RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    chk32("rdata", e, rdata);
    chk32("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle

  task automatic pulse(input int k);
    ev_v[k] <= 1'b1;
    @(posedge clk);
    ev_v[k] <= 1'b0;
    settle();
  endtask : pulse

  task automatic rst;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask : rst

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ****************************************
  // watchdog and tests
  // ****************************************
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    pcie_rst_n <= 1'b1;
    lan_power_good <= 1'b1;
    @(posedge clk);
    rd(err_regs_pkg::ECC_CTL_OFF, 32'h5511);
    rd(err_regs_pkg::LAN_CTL_OFF, 32'h200);
    rd(err_regs_pkg::ECC_STS_OFF, '0);
    rd(err_regs_pkg::LAN_STS_OFF, '0);
    rd(err_regs_pkg::FATAL_MASK_OFF, 32'h1);
    rd(err_regs_pkg::GPAR_CTL_OFF, '0);
    rd(err_regs_pkg::ACL01_OFF, '0);
    rd(err_regs_pkg::IRQ_MASK_OFF, '0);
    chk1("txwr_en", 1'b1, txwr_en);
    chk1("retry_en", 1'b1, retry_en);
    chk1("retx_en", 1'b0, retx_en);
    $display("test reset done");
    acl_w <= '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    acl_load <= 1'b1;
    @(posedge clk);
    acl_load <= 1'b0;
    @(posedge clk);
    rd(err_regs_pkg::ACL01_OFF, 32'h22221111);
    rd(err_regs_pkg::ACL23_OFF, 32'h44443333);
    wr(err_regs_pkg::ACL01_OFF, 32'hffffffff);
    rd(err_regs_pkg::ACL01_OFF, 32'h22221111);
    $display("test acl done");
    pulse(0);
    rd(err_regs_pkg::ECC_STS_OFF, 32'h10);
    pulse(1);
    rd(err_regs_pkg::ECC_STS_OFF, 32'h30);
    chk1("tx_halt", 1'b0, tx_halt);
    wr(err_regs_pkg::ECC_STS_OFF, 32'h10);
    rd(err_regs_pkg::ECC_STS_OFF, 32'h20);
    wr(err_regs_pkg::ECC_STS_OFF, 32'h20);
    rd(err_regs_pkg::ECC_STS_OFF, '0);
    wr(err_regs_pkg::ECC_CTL_OFF, '0);
    rd(err_regs_pkg::ECC_CTL_OFF, 32'h511);
    settle();
    chk1("txwr_en", 1'b0, txwr_en);
    chk1("retry_en", 1'b0, retry_en);
    pulse(0);
    pulse(1);
    rd(err_regs_pkg::ECC_STS_OFF, '0);
    wr(err_regs_pkg::ECC_CTL_OFF, 32'h5000);
    $display("test ecc done");
    pulse(2);
    rd(err_regs_pkg::LAN_STS_OFF, '0);
    chk1("tx_halt", 1'b0, tx_halt);
    wr(err_regs_pkg::GPAR_CTL_OFF, 32'h1);
    pulse(2);
    chk1("retx_en", 1'b1, retx_en);
    rd(err_regs_pkg::LAN_STS_OFF, 32'h200);
    chk1("tx_halt", 1'b1, tx_halt);
    chk1("fatal_ind", 1'b1, fatal_ind);
    chk1("fatal_cause", 1'b1, fatal_cause);
    wr(err_regs_pkg::LAN_STS_OFF, 32'h200);
    settle();
    chk1("tx_halt", 1'b0, tx_halt);
    wr(err_regs_pkg::FATAL_MASK_OFF, '0);
    pulse(2);
    chk1("fatal_ind", 1'b1, fatal_ind);
    chk1("fatal_cause", 1'b0, fatal_cause);
    rst();
    settle();
    chk1("tx_halt", 1'b0, tx_halt);
    rd(err_regs_pkg::GPAR_CTL_OFF, 32'h1);
    rd(err_regs_pkg::ACL01_OFF, 32'h22221111);
    wr(err_regs_pkg::LAN_CTL_OFF, '0);
    pulse(2);
    rd(err_regs_pkg::LAN_STS_OFF, '0);
    lan_power_good <= 1'b0;
    @(posedge clk);
    lan_power_good <= 1'b1;
    @(posedge clk);
    rd(err_regs_pkg::GPAR_CTL_OFF, '0);
    pcie_rst_n <= 1'b0;
    @(posedge clk);
    pcie_rst_n <= 1'b1;
    @(posedge clk);
    rd(err_regs_pkg::ACL01_OFF, '0);
    rd(err_regs_pkg::ACL23_OFF, '0);
    $display("test retx done");
    wr(err_regs_pkg::IRQ_MASK_OFF, 32'h1);
    pulse(0);
    chk1("irq", 1'b1, irq);
    rd(err_regs_pkg::IRQ_STS_OFF, 32'h1);
    settle();
    chk1("irq", 1'b0, irq);
    wr(err_regs_pkg::IRQ_MASK_OFF, '0);
    pulse(0);
    chk1("irq", 1'b0, irq);
    rd(err_regs_pkg::IRQ_STS_OFF, 32'h1);
    rd(16'h0000, 32'h0, SE);
    wr(16'h0000, 32'h1, SE);
    $display("test irq done");
    stop_test();
  end
endmodule : tb
